// File: src/supervisor_reset_watchdog.sv
/*
  Reset supervisor with manual reset and watchdog, top level.
  Assumes supply_low_in and watchdog_float_in come from logic already
  on clock; the two pins are asynchronous and are synchronised here.
*/
module supervisor_reset_watchdog #(
  parameter logic [31:0] HOLD_CYCLES = supervisor_pkg::RESET_HOLD_CYCLES,
  parameter logic [31:0] WD_CYCLES = supervisor_pkg::WATCHDOG_PERIOD_CYCLES,
  parameter logic [7:0] MR_FILTER = supervisor_pkg::MR_FILTER_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic supply_low_in,
  input wire logic manual_reset_n_in,
  input wire logic watchdog_strobe_in,
  input wire logic watchdog_float_in,
  output logic reset_n_out,
  output logic reset_out
);

  // ***************************************************************
  // Elaboration checks
  // ***************************************************************
  if (HOLD_CYCLES < 32'h2 || WD_CYCLES < 32'h2) begin : g_bad_counts
    $error("supervisor_reset_watchdog: cycle counts must be at least two");
  end

  // ***************************************************************
  // Declarations
  // ***************************************************************
  supervisor_pkg::sup_state_t state; // Present state
  supervisor_pkg::sup_state_t next_state; // State for the next edge
  logic mr_level; // Qualified manual reset level, low asserts
  logic strobe_edge; // One-cycle pulse per qualified strobe edge
  logic source; // Undervoltage or manual reset active
  logic hold_done; // Last cycle of the hold time
  logic wd_expire; // Watchdog period ran out this cycle
  logic [31:0] hold_count; // Cycles spent in the hold state
  logic [31:0] wd_count; // Cycles since release or last strobe

  // ***************************************************************
  // Pin qualification
  // ***************************************************************
  // Manual reset: filter well above 100 ns, well below 1 us
  pin_qualifier #(
    .FILTER_CYCLES(MR_FILTER),
    .IDLE_LEVEL(supervisor_pkg::MR_IDLE_LEVEL)
  ) u_mr_qual (
    .clock(clock),
    .rst_b(rst_b),
    .pin(manual_reset_n_in),
    .level(mr_level),
    .change()
  );

  // Watchdog strobe: both edges are reported
  pin_qualifier #(
    .FILTER_CYCLES(supervisor_pkg::STROBE_FILTER_CYCLES),
    .IDLE_LEVEL(supervisor_pkg::STROBE_IDLE_LEVEL)
  ) u_strobe_qual (
    .clock(clock),
    .rst_b(rst_b),
    .pin(watchdog_strobe_in),
    .level(),
    .change(strobe_edge)
  );

  // ***************************************************************
  // Reset sources and timer terminals
  // ***************************************************************
  // Either level source forces the assert state
  assign source = supply_low_in || !mr_level;
  // Hold ends after exactly HOLD_CYCLES cycles in the hold state
  assign hold_done = (hold_count == HOLD_CYCLES - 32'h1);
  // A strobe on the final cycle still counts as in time
  assign wd_expire = (state == supervisor_pkg::ST_RUN) && !watchdog_float_in
    && !strobe_edge && (wd_count == WD_CYCLES - 32'h1);

  // ***************************************************************
  // State machine
  // ***************************************************************
  // Sources win over every other transition
  always_comb begin
    next_state = state;
    case (state)
      supervisor_pkg::ST_ASSERT: begin
        // Held while a source stands, then timed hold
        next_state = source ? supervisor_pkg::ST_ASSERT : supervisor_pkg::ST_HOLD;
      end
      supervisor_pkg::ST_HOLD: begin
        if (source) begin
          next_state = supervisor_pkg::ST_ASSERT;
        end else if (hold_done) begin
          next_state = supervisor_pkg::ST_RUN;
        end
      end
      supervisor_pkg::ST_RUN: begin
        if (source) begin
          next_state = supervisor_pkg::ST_ASSERT;
        end else if (wd_expire) begin
          next_state = supervisor_pkg::ST_HOLD;
        end
      end
      default: begin
        // Unused code: fall back to asserting reset
        next_state = supervisor_pkg::ST_ASSERT;
      end
    endcase
  end

  // State register; reset starts with reset asserted
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= supervisor_pkg::ST_ASSERT;
    end else begin
      state <= next_state;
    end
  end

  // ***************************************************************
  // Hold timer
  // ***************************************************************
  // Counts only while staying in hold, so every entry starts from zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hold_count <= 32'h0;
    end else if (state == supervisor_pkg::ST_HOLD && next_state == supervisor_pkg::ST_HOLD) begin
      hold_count <= hold_count + 32'h1;
    end else begin
      hold_count <= 32'h0;
    end
  end

  // ***************************************************************
  // Watchdog timer
  // ***************************************************************
  // Cleared whenever reset stands, on a strobe, and while floating
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wd_count <= 32'h0;
    end else if (state != supervisor_pkg::ST_RUN || next_state != supervisor_pkg::ST_RUN) begin
      wd_count <= 32'h0;
    end else if (watchdog_float_in || strobe_edge) begin
      wd_count <= 32'h0;
    end else begin
      wd_count <= wd_count + 32'h1;
    end
  end

  // ***************************************************************
  // Reset outputs
  // ***************************************************************
  // Both from next_state, so they switch on the same edge
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reset_n_out <= 1'b0;
      reset_out <= 1'b1;
    end else begin
      reset_n_out <= (next_state == supervisor_pkg::ST_RUN);
      reset_out <= (next_state != supervisor_pkg::ST_RUN);
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  // Reference count of quiet released cycles, taken from the outputs
  // and not from wd_count, so the period check does not restate the timer
  logic [31:0] quiet_count;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      quiet_count <= 32'h0;
    end else if (!reset_n_out || watchdog_float_in || strobe_edge) begin
      // Reset standing, pin released or strobe seen: start again
      quiet_count <= 32'h0;
    end else begin
      quiet_count <= quiet_count + 32'h1;
    end
  end

  property p_complement;
    @(posedge clock) disable iff (!rst_b)
    reset_out == !reset_n_out;
  endproperty
  a_complement: assert property (p_complement)
    else $error("reset outputs are not complementary");

  property p_supply_asserts;
    @(posedge clock) disable iff (!rst_b)
    supply_low_in |=> !reset_n_out && state == supervisor_pkg::ST_ASSERT;
  endproperty
  a_supply_asserts: assert property (p_supply_asserts)
    else $error("undervoltage did not assert reset");

  property p_manual_asserts;
    @(posedge clock) disable iff (!rst_b)
    !mr_level |=> !reset_n_out && reset_out;
  endproperty
  a_manual_asserts: assert property (p_manual_asserts)
    else $error("manual reset did not assert reset");

  property p_full_hold;
    @(posedge clock) disable iff (!rst_b)
    $rose(reset_n_out) |-> $past(state) == supervisor_pkg::ST_HOLD
      && $past(hold_count) == HOLD_CYCLES - 32'h1;
  endproperty
  a_full_hold: assert property (p_full_hold)
    else $error("reset released before the full hold time");

  property p_idle_in_reset;
    @(posedge clock) disable iff (!rst_b)
    !reset_n_out |-> wd_count == 32'h0;
  endproperty
  a_idle_in_reset: assert property (p_idle_in_reset)
    else $error("watchdog counted while reset asserted");

  property p_strobe_restarts;
    @(posedge clock) disable iff (!rst_b)
    (state == supervisor_pkg::ST_RUN && strobe_edge) |=> wd_count == 32'h0;
  endproperty
  a_strobe_restarts: assert property (p_strobe_restarts)
    else $error("strobe edge did not restart the watchdog");

  property p_float_disables;
    @(posedge clock) disable iff (!rst_b)
    watchdog_float_in |-> !wd_expire ##1 wd_count == 32'h0;
  endproperty
  a_float_disables: assert property (p_float_disables)
    else $error("watchdog active while strobe floats");

  property p_expire_holds;
    @(posedge clock) disable iff (!rst_b)
    (wd_expire && !source) |=> state == supervisor_pkg::ST_HOLD
      && hold_count == 32'h0 && !reset_n_out;
  endproperty
  a_expire_holds: assert property (p_expire_holds)
    else $error("watchdog expiry did not start a reset hold");

  property p_source_clears;
    @(posedge clock) disable iff (!rst_b)
    source |=> wd_count == 32'h0 && hold_count == 32'h0;
  endproperty
  a_source_clears: assert property (p_source_clears)
    else $error("timers not cleared by a reset source");

  property p_period_exact;
    @(posedge clock) disable iff (!rst_b)
    wd_expire == (reset_n_out && !watchdog_float_in && !strobe_edge
      && quiet_count == WD_CYCLES - 32'h1);
  endproperty
  a_period_exact: assert property (p_period_exact)
    else $error("watchdog expired at the wrong count");

  // Main scenarios
  c_wd_expire: cover property (@(posedge clock) disable iff (!rst_b) wd_expire);
  c_release: cover property (@(posedge clock) disable iff (!rst_b) $rose(reset_n_out));
  c_manual: cover property (@(posedge clock) disable iff (!rst_b) $fell(mr_level));
  c_strobe: cover property (@(posedge clock) disable iff (!rst_b)
    state == supervisor_pkg::ST_RUN && strobe_edge);

endmodule

// File: src/supervisor_pkg.sv
/*
  Constants and types for the reset supervisor with watchdog.
  Assumes a single free-running 25 MHz clock; all times below are
  converted to whole clock cycles here.
*/
package supervisor_pkg;

  // ***************************************************************
  // Timebase
  // ***************************************************************
  // Free-running clock rate in hertz
  localparam int unsigned CLOCK_HZ = 25_000_000;
  // Cycles per millisecond, reused for every long interval
  localparam int unsigned CYCLES_PER_MS = CLOCK_HZ / 1000;

  // ***************************************************************
  // Timing figures in their own units
  // ***************************************************************
  // Reset hold time, typical, in milliseconds (window 140 to 280)
  localparam int unsigned RESET_HOLD_TIME_MS = 200;
  // Watchdog period, typical, in milliseconds (window 1120 to 2400)
  localparam int unsigned WATCHDOG_PERIOD_MS = 1600;
  // Manual reset qualification time in nanoseconds
  localparam int unsigned MR_FILTER_NS = 500;

  // ***************************************************************
  // Derived cycle counts
  // ***************************************************************
  // Hold time: 5,000,000 cycles at the nominal rate
  localparam logic [31:0] RESET_HOLD_CYCLES = 32'(CYCLES_PER_MS * RESET_HOLD_TIME_MS);
  // Watchdog period: 40,000,000 cycles at the nominal rate
  localparam logic [31:0] WATCHDOG_PERIOD_CYCLES = 32'(CYCLES_PER_MS * WATCHDOG_PERIOD_MS);
  // Least time, so rounded up: 13 cycles
  localparam logic [7:0] MR_FILTER_CYCLES =
    8'((MR_FILTER_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000);
  // Strobe edges need no qualification beyond the synchroniser
  localparam logic [7:0] STROBE_FILTER_CYCLES = 8'h01;

  // ***************************************************************
  // Reset levels and states
  // ***************************************************************
  // Manual reset pin idles high
  localparam logic MR_IDLE_LEVEL = 1'b1;
  // Strobe pin assumed low before the first sample
  localparam logic STROBE_IDLE_LEVEL = 1'b0;

  // Gray coded along assert, hold, run
  typedef enum logic [1:0] {
    ST_ASSERT = 2'h0,
    ST_HOLD = 2'h1,
    ST_RUN = 2'h3
  } sup_state_t;

endpackage

// File: src/pin_qualifier.sv
/*
  Synchroniser and level qualifier for one asynchronous input pin.
  Assumes the pin is unrelated to clock; emits a qualified level and
  a one-cycle pulse on every accepted change of that level.
*/
module pin_qualifier #(
  parameter logic [7:0] FILTER_CYCLES = 8'h01,
  parameter logic IDLE_LEVEL = 1'b0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic pin,
  output logic level,
  output logic change
);

  // ***************************************************************
  // Elaboration checks
  // ***************************************************************
  if (FILTER_CYCLES == 8'h00) begin : g_bad_filter
    $error("pin_qualifier: FILTER_CYCLES must be at least one");
  end

  // ***************************************************************
  // Three-stage synchroniser
  // ***************************************************************
  logic stage1; // Metastability catcher, read only by stage2
  logic stage2; // Second stage
  logic stage3; // Third stage, compared with stage2
  logic [7:0] count; // Cycles the new level has stood

  // Shift the pin through three flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= IDLE_LEVEL;
      stage2 <= IDLE_LEVEL;
      stage3 <= IDLE_LEVEL;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // ***************************************************************
  // Level qualifier
  // ***************************************************************
  // A short glitch restarts the count, so it never reaches the level
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      level <= IDLE_LEVEL;
      count <= 8'h00;
      change <= 1'b0;
    end else begin
      change <= 1'b0;
      if (stage2 == stage3 && stage3 != level) begin
        // Stable and different: count toward acceptance
        if (count == FILTER_CYCLES - 8'h01) begin
          level <= stage3;
          count <= 8'h00;
          change <= 1'b1;
        end else begin
          count <= count + 8'h01;
        end
      end else begin
        // Unstable or back to the old level
        count <= 8'h00;
      end
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  property p_level_qualified;
    @(posedge clock) disable iff (!rst_b)
    (level != $past(level)) |-> ($past(count) == FILTER_CYCLES - 8'h01) && change;
  endproperty
  a_level_qualified: assert property (p_level_qualified)
    else $error("level changed before the qualification count");

endmodule

// File: verif/host_model.sv
/*
  Host model for the reset supervisor: strobes the watchdog pin.
  Assumes the bench raises run to strobe and float_pin to release it.
*/
module host_model #(
  parameter int STROBE_GAP = 20
) (
  input wire logic clock,
  input wire logic run,
  input wire logic float_pin,
  input wire logic reset_n_out,
  output logic watchdog_strobe_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***************************************************************
  // Strobe generation
  // ***************************************************************
  int gap = 0; // Cycles since the last edge
  logic flipped = 1'b0; // Pin already parked while released
  logic pin_level = 1'b0; // Level the host puts on the strobe pin
  logic float_seen; // Release request, taken at the edge
  logic strobing; // Strobing wanted and reset released, taken at the edge
  assign watchdog_strobe_in = pin_level;
  // Requests taken at the edge, pin moved just after it, so the bench's
  // own drive in that same later step never races with this model
  always @(posedge clock) begin
    float_seen = float_pin;
    strobing = run && reset_n_out;
    #1;
    if (float_seen) begin
      // Released pin: inverse of last level, then still
      if (!flipped) pin_level = ~pin_level;
      flipped = 1'b1;
    end else begin
      flipped = 1'b0;
      if (strobing) begin
        gap = gap + 1;
        // Either direction counts, so a plain toggle will do
        if (gap >= STROBE_GAP) begin
          pin_level = ~pin_level;
          gap = 0;
        end
      end
    end
  end
endmodule

// File: verif/supervisor_reset_watchdog_bench.sv
/*
  Self-checking bench for the reset supervisor with watchdog.
  Assumes shortened counts: hold 20, watchdog 50, manual filter 3.
*/
module supervisor_reset_watchdog_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ***************************************************************
  // Settings and wiring
  // ***************************************************************
  localparam int HOLD = 20; // Shortened hold, in cycles
  localparam int WD = 50; // Shortened watchdog period
  localparam int LIMIT = 3000; // Whole run takes about 800
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic supply_low_in = 1'b0;
  logic manual_reset_n_in = 1'b1;
  logic watchdog_float_in = 1'b0;
  logic run = 1'b0; // Host strobing on
  logic watchdog_strobe_in;
  logic reset_n_out;
  logic reset_out;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;
  always #20 clock = ~clock;
  supervisor_reset_watchdog #(
    .HOLD_CYCLES(32'(HOLD)),
    .WD_CYCLES(32'(WD)),
    .MR_FILTER(8'h03)
  ) supervisor_reset_watchdog_i (
    .clock(clock),
    .rst_b(rst_b),
    .supply_low_in(supply_low_in),
    .manual_reset_n_in(manual_reset_n_in),
    .watchdog_strobe_in(watchdog_strobe_in),
    .watchdog_float_in(watchdog_float_in),
    .reset_n_out(reset_n_out),
    .reset_out(reset_out)
  );
  host_model host_model_i (
    .clock(clock),
    .run(run),
    .float_pin(watchdog_float_in),
    .reset_n_out(reset_n_out),
    .watchdog_strobe_in(watchdog_strobe_in)
  );
  // ***************************************************************
  // Report and compare
  // ***************************************************************
  task automatic finish_test();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_count(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("unexpected count at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  // One cycle, sampled at the falling edge where outputs are settled
  task automatic step();
    @(negedge clock);
    check_bit(reset_out, ~reset_n_out);
  endtask
  // Bounded wait for a reset level; n is the cycles it took
  task automatic wait_out(input logic val, input int lim, output int cnt);
    cnt = 0;
    while (reset_n_out !== val && cnt < lim) begin
      step();
      cnt++;
    end
  endtask
  // Reset must stay released for a whole stretch
  task automatic stay_high(input int len);
    repeat (len) begin
      step();
      check_bit(reset_n_out, 1'b1);
    end
  endtask
  // Inputs move just after the rising edge
  task automatic drive_edge();
    @(posedge clock);
    #1;
  endtask
  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic test_power_on();
    wait_out(1'b1, HOLD + 10, n);
    check_count(n, HOLD, HOLD + 3);
  endtask
  // Long undervoltage: no counting meanwhile, full period after
  task automatic test_supply();
    drive_edge();
    supply_low_in = 1'b1;
    step();
    step();
    check_bit(reset_n_out, 1'b0);
    repeat (3 * WD) step();
    check_bit(reset_n_out, 1'b0);
    drive_edge();
    supply_low_in = 1'b0;
    wait_out(1'b1, HOLD + 10, n);
    check_count(n, HOLD, HOLD + 3);
    wait_out(1'b0, WD + 10, n);
    check_count(n, WD - 1, WD + 2);
    wait_out(1'b1, HOLD + 10, n);
    check_count(n, HOLD - 1, HOLD + 2);
  endtask
  // Short glitch refused, a 1 us press honoured
  task automatic test_manual();
    drive_edge();
    manual_reset_n_in = 1'b0;
    repeat (2) drive_edge();
    manual_reset_n_in = 1'b1;
    stay_high(20);
    drive_edge();
    manual_reset_n_in = 1'b0;
    repeat (15) step();
    check_bit(reset_n_out, 1'b0);
    repeat (11) drive_edge();
    manual_reset_n_in = 1'b1;
    wait_out(1'b1, HOLD + 20, n);
    check_count(n, HOLD + 3, HOLD + 9);
  endtask
  // Regular strobes keep reset off; silence lets it expire
  task automatic test_strobe();
    stay_high(4 * WD);
    run = 1'b0;
    wait_out(1'b0, WD + 10, n);
    check_count(n, WD - 25, WD + 6);
    wait_out(1'b1, HOLD + 10, n);
    check_count(n, HOLD - 1, HOLD + 2);
    run = 1'b1;
  endtask
  // Released pin: watchdog off until the pin is driven again
  task automatic test_float();
    drive_edge();
    run = 1'b0;
    watchdog_float_in = 1'b1;
    stay_high(3 * WD);
    drive_edge();
    watchdog_float_in = 1'b0;
    wait_out(1'b0, WD + 10, n);
    check_count(n, WD - 2, WD + 6);
  endtask
  // ***************************************************************
  // Main sequence and hang guard
  // ***************************************************************
  initial begin
    repeat (8) @(posedge clock);
    #1 rst_b = 1'b1;
    test_power_on();
    test_supply();
    run = 1'b1;
    test_manual();
    test_strobe();
    test_float();
    finish_test();
  end
  // A stuck wait is cut short and counted
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      finish_test();
    end
  end
endmodule
